// ### hdl/sonet_align_pkg.sv
`default_nettype none
package sonet_align_pkg;

    // ****************************************
    // Framing pattern
    // ****************************************
    localparam logic [7:0] FRAME_A1 = 8'hf6;
    localparam logic [7:0] FRAME_A2 = 8'h28;
    localparam logic [47:0] FRAME_PATTERN = {FRAME_A1, FRAME_A1, FRAME_A1,
                                             FRAME_A2, FRAME_A2, FRAME_A2};
    localparam int FRAME_BITS = 48;

    // ****************************************
    // Byte and rate timing
    // ****************************************
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_HALF = 3'h4;
    // Lower rate moves one bit every LOW_RATE_LAST + 1 clocks (622.08 / 155.52)
    localparam logic [1:0] LOW_RATE_LAST = 2'h3;
    localparam real SYS_CLK_MHZ = 20.0;
    localparam real SYS_CLK_PERIOD_NS = 1000.0 / SYS_CLK_MHZ;

    // ****************************************
    // Loss of signal detector
    // ****************************************
    localparam int LOS_WINDOW_BITS = 128;
    localparam logic [7:0] LOS_RUN_LIMIT = 8'h80;
    localparam logic [7:0] LOS_CLEAR_TRANS = 8'h10;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RX_DATA_RESET = 8'h00;
    localparam logic [7:0] TX_WORD_RESET = 8'h00;

    typedef struct packed {
        logic frame;
        logic [7:0] data;
    } rx_byte_t;

endpackage
`default_nettype wire

// ### hdl/los_detector.sv
`default_nettype none
module los_detector
    import sonet_align_pkg::*;
(
    input wire logic sys_clk,      // System clock
    input wire logic nrst,         // Async reset, active low
    input wire logic bit_tick,     // One serial bit period elapsed
    input wire logic rx_bit,       // Current received bit
    output logic los               // Internal loss of signal
);

    logic prev_bit;
    logic [7:0] run_len;
    logic [7:0] trans_count;
    logic [LOS_WINDOW_BITS-1:0] trans_hist;
    logic trans;
    logic [7:0] next_trans_count;

    assign trans = rx_bit ^ prev_bit;
    assign next_trans_count = trans_count + {7'h00, trans}
                              - {7'h00, trans_hist[LOS_WINDOW_BITS-1]};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_bit <= 1'b0;
            trans_hist <= '0;
            trans_count <= 8'h00;
        end else if (bit_tick) begin
            prev_bit <= rx_bit;
            trans_hist <= {trans_hist[LOS_WINDOW_BITS-2:0], trans};
            trans_count <= next_trans_count;
        end
    end

    // Saturating run length; stops one past the limit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            run_len <= 8'h00;
        end else if (bit_tick) begin
            if (trans) begin
                run_len <= 8'h00;
            end else if (run_len <= LOS_RUN_LIMIT) begin
                run_len <= run_len + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            los <= 1'b0;
        end else if (!los && run_len > LOS_RUN_LIMIT) begin
            los <= 1'b1;
        end else if (los && next_trans_count >= LOS_CLEAR_TRANS && bit_tick) begin
            los <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### hdl/sonet_frame_align.sv
`default_nettype none
module sonet_frame_align
    import sonet_align_pkg::*;
(
    input wire logic sys_clk,                // System clock, 20 MHz
    input wire logic nrst,                   // Async reset, active low
    input wire logic rate_select,            // 1 higher rate, 0 lower rate
    input wire logic rx_serial_in,           // Recovered serial data
    input wire logic frame_search_request,   // Framer asks for a pattern hunt
    input wire logic los_detect_disable,     // High turns internal detector off
    input wire logic ext_signal_lost_n,      // External loss, active low
    input wire logic [7:0] tx_parallel_data, // Transmit word from framer
    output logic [7:0] rx_parallel_data,     // Received byte
    output logic rx_byte_clock,              // Receive byte clock
    output logic frame_boundary_pulse,       // Frame found, one byte period
    output logic tx_byte_clock,              // Transmit byte clock
    output logic tx_serial_out,              // Serial transmit data
    output logic signal_lost                 // Loss of signal in force
);

    function automatic logic last_bit(input logic [2:0] cnt);
        last_bit = (cnt == BIT_LAST);
    endfunction

    // ****************************************
    // Bit timing
    // ****************************************
    logic [1:0] rate_cnt;
    logic bit_tick;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rate_cnt <= 2'h0;
        end else if (rate_select) begin
            rate_cnt <= 2'h0;
        end else begin
            rate_cnt <= rate_cnt + 2'h1;
        end
    end

    // Higher rate moves a bit every clock, lower rate every fourth
    assign bit_tick = rate_select || (rate_cnt == LOW_RATE_LAST);

    // ****************************************
    // Receive pattern search
    // ****************************************
    logic [FRAME_BITS-1:0] rx_shift;
    logic [FRAME_BITS-1:0] next_rx_shift;
    logic [2:0] rx_bit_cnt;
    logic pattern_hit;
    logic byte_done;

    assign next_rx_shift = {rx_shift[FRAME_BITS-2:0], rx_serial_in};

    assign pattern_hit = frame_search_request && bit_tick
                         && (next_rx_shift == FRAME_PATTERN);

    // byte closes on count or on a new boundary
    assign byte_done = bit_tick && (pattern_hit || last_bit(rx_bit_cnt));

    // earlier bits shift toward bit 7
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_shift <= '0;
        end else if (bit_tick) begin
            rx_shift <= next_rx_shift;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_bit_cnt <= BIT_FIRST;
        end else if (byte_done) begin
            rx_bit_cnt <= BIT_FIRST;
        end else if (bit_tick) begin
            rx_bit_cnt <= rx_bit_cnt + 3'h1;
        end
    end

    // ****************************************
    // Loss of signal
    // ****************************************
    logic internal_los;
    logic los_now;

    los_detector u_los (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .bit_tick(bit_tick),
        .rx_bit(rx_serial_in),
        .los(internal_los)
    );

    // detector gated by disable, external input active low
    // external loss only while detection is enabled
    assign los_now = !los_detect_disable && (internal_los || !ext_signal_lost_n);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            signal_lost <= 1'b0;
        end else begin
            signal_lost <= los_now;
        end
    end

    // ****************************************
    // Receive byte output
    // ****************************************
    rx_byte_t rx_out;
    rx_byte_t next_rx_out;

    always_comb begin
        next_rx_out = rx_out;
        if (byte_done) begin
            next_rx_out.data = next_rx_shift[BYTE_BITS-1:0];
            next_rx_out.frame = pattern_hit;
        end
        // mute at once, so a byte launched before the loss does not linger
        if (los_now) begin
            next_rx_out.data = RX_DATA_RESET;
        end
        // dropping the request ends a pulse at once
        if (!frame_search_request) begin
            next_rx_out.frame = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_out <= '{frame: 1'b0, data: RX_DATA_RESET};
        end else begin
            rx_out <= next_rx_out;
        end
    end

    assign rx_parallel_data = rx_out.data;
    assign frame_boundary_pulse = rx_out.frame;

    // clock falls when a byte is launched, rises mid byte
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_byte_clock <= 1'b0;
        end else if (byte_done) begin
            rx_byte_clock <= 1'b0;
        end else if (bit_tick && rx_bit_cnt == BIT_HALF - 3'h1) begin
            rx_byte_clock <= 1'b1;
        end
    end

    // ****************************************
    // Transmit path
    // ****************************************
    logic [2:0] tx_bit_cnt;
    logic [7:0] tx_hold;
    logic [7:0] tx_shift;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_bit_cnt <= BIT_FIRST;
        end else if (bit_tick) begin
            tx_bit_cnt <= tx_bit_cnt + 3'h1;
        end
    end

    // divide bit clock by eight; high for the second half of a byte
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_byte_clock <= 1'b0;
        end else if (bit_tick) begin
            tx_byte_clock <= (tx_bit_cnt >= BIT_HALF - 3'h1) && !last_bit(tx_bit_cnt);
        end
    end

    // capture at rising edge of byte clock
    // framer drives data from the falling edge, so it is settled here
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_hold <= TX_WORD_RESET;
        end else if (bit_tick && tx_bit_cnt == BIT_HALF - 3'h1) begin
            tx_hold <= tx_parallel_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_shift <= TX_WORD_RESET;
        end else if (bit_tick) begin
            if (last_bit(tx_bit_cnt)) begin
                tx_shift <= tx_hold;
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_serial_out <= 1'b0;
        end else if (bit_tick) begin
            tx_serial_out <= last_bit(tx_bit_cnt) ? tx_hold[7] : tx_shift[6];
        end
    end

endmodule
`default_nettype wire

// ### sim/sonet_frame_align_checker.sv
`default_nettype none
module sonet_frame_align_checker
    import sonet_align_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic rate_select, // Rate
    input wire logic frame_search_request, // Hunt
    input wire logic los_detect_disable, // Loss off
    input wire logic ext_signal_lost_n, // Ext loss
    input wire logic [7:0] tx_parallel_data, // Tx word
    input wire logic [7:0] rx_parallel_data, // Rx byte
    input wire logic rx_byte_clock, // Rx clock
    input wire logic frame_boundary_pulse, // Frame
    input wire logic tx_byte_clock, // Tx clock
    input wire logic tx_serial_out, // Tx bit
    input wire logic signal_lost // Loss
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Word taken at the last rise; the framer holds it past that edge
    logic [7:0] cap_w;
    logic tbc_d;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cap_w <= 8'h00;
            tbc_d <= 1'b0;
        end else begin
            tbc_d <= tx_byte_clock;
            if (tx_byte_clock && !tbc_d) begin
                cap_w <= tx_parallel_data;
            end
        end
    end
    // ****
    // Assertions
    // ****
    pulse_needs_hunt_a: assert property (!frame_search_request [*2] |-> !frame_boundary_pulse)
        else $error("pulse without hunt");
    pulse_width_a: assert property (rate_select && $rose(frame_boundary_pulse) |->
        (frame_boundary_pulse || !frame_search_request) [*8] ##1 !frame_boundary_pulse)
        else $error("pulse width");
    pulse_on_a2_a: assert property ($rose(frame_boundary_pulse) && !signal_lost |->
        rx_parallel_data == FRAME_A2 && !rx_byte_clock) else $error("pulse not on A2");
    rx_clk_phase_a: assert property ($fell(rx_byte_clock) && rate_select &&
        !frame_search_request |-> !rx_byte_clock [*4] ##1 rx_byte_clock)
        else $error("rx clock phase");
    loss_mute_a: assert property (signal_lost [*2] |-> rx_parallel_data == 8'h00)
        else $error("data not muted");
    ext_loss_a: assert property (!los_detect_disable && !ext_signal_lost_n |->
        ##[1:2] signal_lost) else $error("external loss ignored");
    detect_off_a: assert property (los_detect_disable |=> !signal_lost)
        else $error("loss while disabled");
    tx_clk_div_a: assert property (rate_select && $rose(tx_byte_clock) |->
        tx_byte_clock [*4] ##1 !tx_byte_clock [*4] ##1 tx_byte_clock) else $error("tx clock");
    tx_bit_order_a: assert property (rate_select && $rose(tx_byte_clock) |->
        ##4 tx_serial_out == cap_w[7] ##4 tx_serial_out == cap_w[3]) else $error("tx order");
endmodule
bind sonet_frame_align sonet_frame_align_checker sonet_frame_align_checker_inst (
    .sys_clk, .nrst, .rate_select, .frame_search_request, .los_detect_disable,
    .ext_signal_lost_n, .tx_parallel_data, .rx_parallel_data, .rx_byte_clock,
    .frame_boundary_pulse, .tx_byte_clock, .tx_serial_out, .signal_lost);
`default_nettype wire

// ### sim/framer_model.sv
`default_nettype none
module framer_model (
    input wire logic sys_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic tx_byte_clock, // Device byte clock
    output logic [7:0] tx_parallel_data // Word to send
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tbc_d;
    // words follow tx_byte_clock
    // New word just after the fall, so it stands still at the next rise
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tbc_d <= 1'b0;
            tx_parallel_data <= 8'h5c;
        end else begin
            tbc_d <= tx_byte_clock;
            if (tbc_d && !tx_byte_clock) begin
                tx_parallel_data <= tx_parallel_data + 8'h3b;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/sonet_frame_align_tb.sv
`default_nettype none
module sonet_frame_align_tb
    import sonet_align_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] d;
        logic dis;
        logic ext_n;
        logic [7:0] e;
    } row_t;
    logic sys_clk, nrst, rate_select, rx_serial_in, frame_search_request, los_detect_disable;
    logic ext_signal_lost_n, rx_byte_clock, frame_boundary_pulse, tx_byte_clock, tx_serial_out;
    logic signal_lost, prev_rbc = 1'b0, prev_fp = 1'b0, prev_tbc = 1'b0;
    logic [7:0] tx_parallel_data, rx_parallel_data;
    logic [8:0] rxq[$];
    int errors, cmp_count, div, pw, last_pw, tp, last_tp, k;
    row_t rows[8] = '{{8'h3c, 2'b01, 8'h3c}, {8'ha5, 2'b01, 8'ha5}, {8'h01, 2'b01, 8'h01},
        {8'h80, 2'b01, 8'h80}, {8'h5a, 2'b00, 8'h00}, {8'hc3, 2'b10, 8'hc3},
        {8'hff, 2'b11, 8'hff}, {8'h96, 2'b01, 8'h96}};
    sonet_frame_align sonet_frame_align_inst (.sys_clk, .nrst, .rate_select, .rx_serial_in,
        .frame_search_request, .los_detect_disable, .ext_signal_lost_n, .tx_parallel_data,
        .rx_parallel_data, .rx_byte_clock, .frame_boundary_pulse, .tx_byte_clock,
        .tx_serial_out, .signal_lost);
    framer_model framer_model_inst (.sys_clk, .nrst, .tx_byte_clock, .tx_parallel_data);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Loss inputs move mid-byte, once the monitor has recorded the byte launched before
    task automatic send(input logic [7:0] b, input logic dis = 1'b0, input logic en = 1'b1);
        for (int i = 7; i >= 0; i--) begin
            repeat (div) @(posedge sys_clk);
            rx_serial_in <= b[i];
            if (i == 3) begin
                los_detect_disable <= dis;
                ext_signal_lost_n <= en;
            end
        end
    endtask
    task automatic pattern();
        for (int j = 0; j < 6; j++) send(FRAME_PATTERN[47 - 8 * j -: 8]);
    endtask
    // ****
    // Monitor
    // ****
    always @(posedge sys_clk) begin
        if ((prev_rbc && !rx_byte_clock) || (frame_boundary_pulse && !prev_fp)) begin
            rxq.push_back({frame_boundary_pulse, rx_parallel_data});
        end
        if (frame_boundary_pulse) begin
            pw++;
        end else if (pw != 0) begin
            last_pw = pw;
            pw = 0;
        end
        tp++;
        if (tx_byte_clock && !prev_tbc) begin
            last_tp = tp;
            tp = 0;
        end
        prev_rbc = rx_byte_clock;
        prev_fp = frame_boundary_pulse;
        prev_tbc = tx_byte_clock;
    end
    initial begin
        nrst = 1'b0;
        rate_select = 1'b1;
        rx_serial_in = 1'b0;
        frame_search_request = 1'b0;
        los_detect_disable = 1'b0;
        ext_signal_lost_n = 1'b1;
        div = 1;
        repeat (6) @(posedge sys_clk);
        check({frame_boundary_pulse, rx_parallel_data}, 9'h000);
        check({6'h00, tx_byte_clock, signal_lost, rx_byte_clock}, 9'h000);
        nrst <= 1'b1;
        frame_search_request <= 1'b1;
        send(8'h33);
        pattern();
        foreach (rows[i]) send(rows[i].d, rows[i].dis, rows[i].ext_n);
        repeat (3) @(posedge sys_clk);
        k = 0;
        while (k < rxq.size() && !rxq[k][8]) k++;
        check(rxq[k], {1'b1, FRAME_A2});
        foreach (rows[i]) check(rxq[k + 1 + i], {1'b0, rows[i].e});
        check(9'(last_pw), 9'd8);
        check(9'(last_tp), 9'd8);
        repeat (17) send(8'h00);
        check({rx_parallel_data, signal_lost}, 9'h001);
        send(8'h55);
        check({8'h00, signal_lost}, 9'h001);
        repeat (2) send(8'h55);
        check({8'h00, signal_lost}, 9'h000);
        rxq.delete();
        pattern();
        send(8'h69);
        frame_search_request <= 1'b0;
        pattern();
        send(8'ha5);
        repeat (3) @(posedge sys_clk);
        check(rxq[$], {1'b0, 8'ha5});
        k = 0;
        foreach (rxq[i]) k += rxq[i][8];
        check(9'(k), 9'd1);
        nrst <= 1'b0;
        rate_select <= 1'b0;
        div = 4;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        frame_search_request <= 1'b1;
        rxq.delete();
        send(8'h33);
        pattern();
        send(8'hb4);
        repeat (12) @(posedge sys_clk);
        k = 0;
        while (k < rxq.size() && !rxq[k][8]) k++;
        check(rxq[k], {1'b1, FRAME_A2});
        check(rxq[k + 1], {1'b0, 8'hb4});
        check(9'(last_pw), 9'd32);
        check(9'(last_tp), 9'd32);
        report_and_stop();
    end
    // Far beyond the fewer than seven hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
